// ### hw/mfe_pkg.sv
// Purpose: Shared constants and types for the management frame engine
// Assumes: 32-bit classic Wishbone register bus, 125 MHz clock
// Notes: Offsets are word aligned byte addresses
package mfe_pkg;

  localparam logic [7:0] ADDR_WORD = 8'h00;
  localparam logic [7:0] ADDR_DIV = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h14;

  localparam int KIND_HI = 29;
  localparam int KIND_LO = 28;
  localparam int DATA_HI = 15;
  localparam int NO_PRE_BIT = 7;
  localparam int DIV_HI = 6;
  localparam int DIV_LO = 1;
  localparam int DIV_W = 6;
  localparam int PRE_LEN = 32;
  localparam int FRAME_LEN = 32;
  // Bit index (counting down from 31) at which a read releases the line
  localparam int TURN2_IDX = 16;

  localparam logic [DIV_W-1:0] DIV_OFF = 6'h00;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0]
  {
    MFE_IDLE,
    MFE_PRE,
    MFE_SHIFT,
    MFE_DONE
  } mfe_state_type;

  typedef struct packed
  {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } mfe_wb_req_type;

endpackage

// ### hw/mfe_clk_div.sv
// Purpose: Management clock divider producing edge enables
// Assumes: Divider value zero holds the clock low
// Notes: Change of divider acts at once on the running count, so the current half period is cut or stretched
`timescale 1ns/1ps
module mfe_clk_div
#(
  parameter int DIV_W = 6
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [DIV_W-1:0] div_i,
  output logic mdc_o,
  output logic rise_o,
  output logic fall_o
);

  logic [DIV_W-1:0] cnt;
  wire div_zero = (div_i == '0);
  wire hit = !div_zero && (cnt + 1'b1 >= div_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || div_zero)
    begin
      cnt <= '0;
      mdc_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
    else
    begin
      cnt <= hit ? '0 : cnt + 1'b1;
      if (hit)
        mdc_o <= !mdc_o;
      rise_o <= hit && !mdc_o;
      fall_o <= hit && mdc_o;
    end
  end

endmodule

// ### hw/mfe_top.sv
// Purpose: Management frame engine with Wishbone registers
// Assumes: One clock at 125 MHz, synchronous active high reset
// Notes: Data line is three signals; output enable high while driving
//
// Function
// - Word write launches frame when idle, unless divider zero
// - Later nonzero divider launches pending word
// - Opcode high bit selects read or write
// - PHY and register addresses sent in frame
// - Data bits sent on write, captured on read
// - Preamble first, then word shifted out serially
// - Word register changes while shifting
// - Write completion interrupts, word restored
// - Read completion interrupts, data replaced
// - Word write during frame alters frame
// - No-preamble bit skips the thirty-two ones
// - Divider sets clock; zero holds it low
// - Fifty percent duty; changes act on the current half period
// - Word register has no reset value
`timescale 1ns/1ps
module mfe_top
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic MGMT_CLK_PIN_O,
  output logic MDIO_O,
  output logic MDIO_OE_O,
  input wire logic MDIO_I,
  output logic IRQ_O
);

  mfe_pkg::mfe_wb_req_type req;
  assign req = '{cyc: CYC_I, stb: STB_I, we: WE_I, sel: SEL_I, adr: ADR_I, dat: DAT_I};

  logic [31:0] mgmt_word_reg;
  logic [31:0] orig_word;
  logic no_preamble;
  logic [mfe_pkg::DIV_W-1:0] clk_div;
  logic pending;
  logic irq_stat;
  logic irq_en;
  logic [15:0] rd_shift;
  logic [5:0] bit_cnt;
  logic is_read;
  logic mdio_s1;
  logic mdio_s2;
  mfe_pkg::mfe_state_type state;

  wire mdc_rise;
  wire mdc_fall;
  wire mdc;

  mfe_clk_div #(.DIV_W(mfe_pkg::DIV_W)) u_div
  (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .div_i(clk_div),
    .mdc_o(mdc),
    .rise_o(mdc_rise),
    .fall_o(mdc_fall)
  );

  // Bus decode
  function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] off);
    hit_addr = (a == off);
  endfunction

  wire access = req.cyc && req.stb && !ACK_O;
  wire wr = access && req.we;
  wire wr_word = wr && hit_addr(req.adr, mfe_pkg::ADDR_WORD);
  wire wr_div = wr && hit_addr(req.adr, mfe_pkg::ADDR_DIV);
  wire wr_clr = wr && hit_addr(req.adr, mfe_pkg::ADDR_IRQ_CLR);
  wire wr_en = wr && hit_addr(req.adr, mfe_pkg::ADDR_IRQ_EN);
  wire busy = (state != mfe_pkg::MFE_IDLE);

  // Byte lanes merged into word and divider writes
  wire [31:0] word_wdata =
  {
    req.sel[3] ? req.dat[31:24] : mgmt_word_reg[31:24],
    req.sel[2] ? req.dat[23:16] : mgmt_word_reg[23:16],
    req.sel[1] ? req.dat[15:8] : mgmt_word_reg[15:8],
    req.sel[0] ? req.dat[7:0] : mgmt_word_reg[7:0]
  };
  wire [mfe_pkg::DIV_W-1:0] next_div =
    req.sel[0] ? req.dat[mfe_pkg::DIV_HI:mfe_pkg::DIV_LO] : clk_div;
  wire next_no_pre = req.sel[0] ? req.dat[mfe_pkg::NO_PRE_BIT] : no_preamble;

  wire div_live = (clk_div != mfe_pkg::DIV_OFF);
  wire div_new_live = (next_div != mfe_pkg::DIV_OFF);
  // Launch request: word write with live divider, or divider wakes a pending word
  wire launch_word = wr_word && div_live && !busy;
  wire launch_div = wr_div && pending && div_new_live && !busy;
  wire launch = launch_word || launch_div;

  wire frame_end = (state == mfe_pkg::MFE_SHIFT) && mdc_fall && (bit_cnt == 6'd0);
  wire done_evt = (state == mfe_pkg::MFE_DONE);

  wire [31:0] status_word = {31'h0000_0000, busy};
  wire [31:0] rdata =
    hit_addr(req.adr, mfe_pkg::ADDR_WORD) ? mgmt_word_reg :
    hit_addr(req.adr, mfe_pkg::ADDR_DIV) ?
      {24'h00_0000, no_preamble, clk_div, 1'b0} :
    hit_addr(req.adr, mfe_pkg::ADDR_STATUS) ? status_word :
    hit_addr(req.adr, mfe_pkg::ADDR_IRQ_STAT) ? {31'h0000_0000, irq_stat} :
    hit_addr(req.adr, mfe_pkg::ADDR_IRQ_EN) ? {31'h0000_0000, irq_en} :
    mfe_pkg::ZERO_WORD;

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      ACK_O <= 1'b0;
      DAT_O <= mfe_pkg::ZERO_WORD;
    end
    else
    begin
      ACK_O <= access;
      DAT_O <= (access && !req.we) ? rdata : mfe_pkg::ZERO_WORD;
    end
  end

  // Divider register and interrupt control
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      clk_div <= mfe_pkg::DIV_OFF;
      no_preamble <= 1'b0;
      irq_en <= 1'b0;
      irq_stat <= 1'b0;
      IRQ_O <= 1'b0;
    end
    else
    begin
      if (wr_div)
      begin
        clk_div <= next_div;
        no_preamble <= next_no_pre;
      end
      if (wr_en)
        irq_en <= req.dat[0];
      // Set wins over a clear in the same cycle
      irq_stat <= done_evt || (irq_stat && !(wr_clr && req.dat[0]));
      IRQ_O <= irq_stat && irq_en;
    end
  end

  // Pending word waits for a non-zero divider
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      pending <= 1'b0;
    else if (launch)
      pending <= 1'b0;
    else if (wr_word && !div_live)
      pending <= 1'b1;
  end

  // Word register is not reset; it serves as the shift register
  always_ff @(posedge REF_CLK_I)
  begin
    if (wr_word)
      mgmt_word_reg <= word_wdata;
    else if (state == mfe_pkg::MFE_SHIFT && mdc_fall)
      mgmt_word_reg <= {mgmt_word_reg[30:0], mgmt_word_reg[31]};
    else if (done_evt && is_read)
      mgmt_word_reg <= {orig_word[31:mfe_pkg::DATA_HI+1], rd_shift};
    else if (done_evt)
      mgmt_word_reg <= orig_word;
  end

  // Copy of the word as launched, so it can be restored; rotation alone
  // leaves it rotated left by one bit, and a mid-frame write alters it too
  always_ff @(posedge REF_CLK_I)
  begin
    if (launch_word)
      orig_word <= word_wdata;
    else if (launch_div || (wr_word && busy))
      orig_word <= wr_word ? word_wdata : mgmt_word_reg;
  end

  // Data line input synchroniser
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      mdio_s1 <= 1'b0;
      mdio_s2 <= 1'b0;
    end
    else
    begin
      mdio_s1 <= MDIO_I;
      mdio_s2 <= mdio_s1;
    end
  end

  // Frame sequencer: output changes on falling clock, PHY data sampled on rising
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      state <= mfe_pkg::MFE_IDLE;
      bit_cnt <= 6'd0;
      is_read <= 1'b0;
      rd_shift <= 16'h0000;
      MDIO_O <= 1'b1;
      MDIO_OE_O <= 1'b0;
    end
    else
    begin
      case (state)
        mfe_pkg::MFE_IDLE:
        begin
          MDIO_OE_O <= 1'b0;
          MDIO_O <= 1'b1;
          if (launch)
          begin
            is_read <= word_or_reg_kind(launch_word, word_wdata, mgmt_word_reg);
            if (no_preamble && !(launch_div && !next_no_pre) ||
                (launch_div && next_no_pre))
            begin
              state <= mfe_pkg::MFE_SHIFT;
              bit_cnt <= 6'(mfe_pkg::FRAME_LEN);
            end
            else
            begin
              state <= mfe_pkg::MFE_PRE;
              bit_cnt <= 6'(mfe_pkg::PRE_LEN);
            end
          end
        end
        mfe_pkg::MFE_PRE:
        begin
          if (mdc_fall)
          begin
            MDIO_OE_O <= 1'b1;
            MDIO_O <= 1'b1;
            bit_cnt <= bit_cnt - 6'd1;
            if (bit_cnt == 6'd1)
            begin
              state <= mfe_pkg::MFE_SHIFT;
              bit_cnt <= 6'(mfe_pkg::FRAME_LEN);
            end
          end
        end
        mfe_pkg::MFE_SHIFT:
        begin
          if (mdc_fall)
          begin
            bit_cnt <= bit_cnt - 6'd1;
            if (frame_end)
            begin
              state <= mfe_pkg::MFE_DONE;
              MDIO_OE_O <= 1'b0;
            end
            else
            begin
              // every field goes out MSB first
              MDIO_O <= mgmt_word_reg[31];
              MDIO_OE_O <= !(is_read && bit_cnt <= 6'(mfe_pkg::TURN2_IDX + 1));
            end
          end
          if (mdc_rise && is_read && bit_cnt < 6'(mfe_pkg::TURN2_IDX))
            rd_shift <= {rd_shift[14:0], mdio_s2};
        end
        mfe_pkg::MFE_DONE:
        begin
          state <= mfe_pkg::MFE_IDLE;
        end
        default:
        begin
          state <= mfe_pkg::MFE_IDLE;
        end
      endcase
    end
  end

  function automatic logic word_or_reg_kind(input logic from_bus, input logic [31:0] bus_word,
                                            input logic [31:0] reg_word);
    word_or_reg_kind = from_bus ? bus_word[mfe_pkg::KIND_HI] : reg_word[mfe_pkg::KIND_HI];
  endfunction

  assign MGMT_CLK_PIN_O = mdc;

endmodule

// ### verif/mfe_top_chk.sv
// Purpose: Port checks for the management frame engine
// Assumes: Register writes use all byte lanes
// Notes: Divider and irq enable are mirrored from bus writes
`timescale 1ns/1ps
module mfe_top_chk
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic MGMT_CLK_PIN_O,
  input wire logic MDIO_O,
  input wire logic MDIO_OE_O,
  input wire logic MDIO_I,
  input wire logic IRQ_O
);
  logic [5:0] div;
  logic [7:0] hc;
  logic en, ch, pc, wr, wd, tg;
  assign wr = CYC_I && STB_I && WE_I && ACK_O;
  assign wd = wr && ADR_I == mfe_pkg::ADDR_DIV;
  assign tg = MGMT_CLK_PIN_O != pc;
  // A divider write distorts one half period, so that one is skipped
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      div <= 6'h00;
      en <= 1'b0;
      ch <= 1'b0;
      hc <= 8'h00;
      pc <= 1'b0;
    end
    else
    begin
      pc <= MGMT_CLK_PIN_O;
      hc <= tg ? 8'h01 : hc + 8'h01;
      ch <= wd || (ch && !tg);
      if (wd)
        div <= DAT_I[6:1];
      if (wr && ADR_I == mfe_pkg::ADDR_IRQ_EN)
        en <= DAT_I[0];
    end
  end
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);
  sequence s_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_done;
    $fell(MDIO_OE_O) ##0 en;
  endsequence
  ack_pulse_a: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  ack_resp_a: assert property (s_req |=> ACK_O)
    else $error("request not acknowledged");
  clk_off_a: assert property (div == 6'h00 && !MGMT_CLK_PIN_O |=> !MGMT_CLK_PIN_O)
    else $error("clock moved with divider zero");
  clk_half_a: assert property (tg && !ch && div != 6'h00 |-> hc == {2'b00, div})
    else $error("clock half period wrong");
  mdio_edge_a: assert property ($changed(MDIO_O) && MDIO_OE_O && $past(MDIO_OE_O) |-> !MGMT_CLK_PIN_O)
    else $error("data changed while clock high");
  busy_flag_a: assert property (ACK_O && !WE_I && ADR_I == mfe_pkg::ADDR_STATUS
    && $past(MDIO_OE_O) |-> DAT_O[0])
    else $error("busy clear during frame");
  irq_done_a: assert property (s_done |-> ##[1:1000] IRQ_O)
    else $error("no interrupt after frame");
  irq_mask_a: assert property (IRQ_O |-> en)
    else $error("interrupt while disabled");
endmodule
bind mfe_top mfe_top_chk mfe_top_chk_inst (.*);

// ### verif/mfe_phy_model.sv
// Purpose: Behavioural management-bus device for the engine's far side
// Assumes: Data line has a pull-up when nobody drives
// Notes: Samples on clock rise, drives read data after clock fall
`timescale 1ns/1ps
module mfe_phy_model
(
  input wire logic mdc_i,
  input wire logic oe_i,
  input wire logic line_i,
  input wire logic [15:0] val_i,
  output logic drv_o,
  output logic dat_o,
  output logic [31:0] got_o,
  output logic [7:0] pre_o
);
  int idx = -1;
  logic [7:0] ones = 8'h00;
  logic rd = 1'b0;
  always @(posedge mdc_i)
  begin
    if (idx < 0)
    begin
      if (oe_i && line_i)
        ones <= ones + 8'h01;
      else if (oe_i)
      begin
        pre_o <= ones;
        ones <= 8'h00;
        got_o[31] <= 1'b0;
        idx <= 30;
      end
    end
    else
    begin
      got_o[idx] <= line_i;
      if (idx == 28)
        rd <= got_o[29];
      idx <= idx - 1;
    end
  end
  // Second turnaround bit is driven low, then sixteen data bits
  always @(negedge mdc_i)
  begin
    drv_o <= rd && idx >= 0 && idx <= 16;
    dat_o <= (idx == 16) ? 1'b0 : val_i[idx[3:0]];
  end
endmodule

// ### verif/tb.sv
// Purpose: Self-checking bench for the management frame engine
// Assumes: Divider kept at 2.5 MHz or below, pull-up on data line
// Notes: Row table covers all four operation codes
`timescale 1ns/1ps
module tb;
  `define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", nm, e, s); end end
  typedef struct packed
  {
    logic nopre;
    logic [5:0] div;
    logic [31:0] w;
    logic [15:0] v;
  } mfe_row_type;
  mfe_row_type rows [4] = '{
    '{1'b0, 6'h19, 32'h58AA_A5C3, 16'h0000},
    '{1'b1, 6'h1A, 32'h61FE_1234, 16'hBEEF},
    '{1'b0, 6'h19, 32'h7F82_0000, 16'h8001},
    '{1'b1, 6'h1B, 32'h4056_FFFF, 16'h0000}};
  mfe_pkg::mfe_wb_req_type req;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] q, rdq, got;
  logic ack, mclk, mdo, moe, irq, drv, pdat, mdio;
  logic [7:0] pre;
  logic [15:0] val = 16'h0000;
  int n_fail = 0;
  int n_checks = 0;
  mfe_top mfe_top_inst
  (
    .REF_CLK_I(clk), .RST_I(rst), .CYC_I(req.cyc), .STB_I(req.stb), .WE_I(req.we),
    .SEL_I(req.sel), .ADR_I(req.adr), .DAT_I(req.dat), .DAT_O(q), .ACK_O(ack),
    .MGMT_CLK_PIN_O(mclk), .MDIO_O(mdo), .MDIO_OE_O(moe), .MDIO_I(mdio), .IRQ_O(irq)
  );
  assign mdio = moe ? mdo : (drv ? pdat : 1'b1);
  mfe_phy_model mfe_phy_model_inst
  (
    .mdc_i(mclk), .oe_i(moe), .line_i(mdio), .val_i(val), .drv_o(drv), .dat_o(pdat),
    .got_o(got), .pre_o(pre)
  );
  always #4 clk = ~clk;
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    req.cyc <= 1'b1;
    req.stb <= 1'b1;
    req.we <= w;
    req.adr <= a;
    req.dat <= d;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    rdq = q;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    if (k >= 50)
      n_fail++;
    @(posedge clk);
  endtask
  task automatic wait_irq();
    int k = 0;
    while (irq !== 1'b1 && k < 8000)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 8000)
      n_fail++;
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    req = '0;
    req.sel = 4'hF;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, mfe_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    foreach (rows[i])
    begin
      val <= rows[i].v;
      bus(1'b1, mfe_pkg::ADDR_DIV, {24'h00_0000, rows[i].nopre, rows[i].div, 1'b0});
      bus(1'b1, mfe_pkg::ADDR_WORD, rows[i].w);
      bus(1'b0, mfe_pkg::ADDR_STATUS, 32'h0000_0000);
      `CHK("busy", 1'b1, rdq[0])
      wait_irq();
      bus(1'b0, mfe_pkg::ADDR_WORD, 32'h0000_0000);
      `CHK("word", rows[i].w[29] ? {rows[i].w[31:16], rows[i].v} : rows[i].w, rdq)
      `CHK("sent", 32'h0000_0000, (got ^ rows[i].w) & (rows[i].w[29] ? 32'hFFFE_0000 : 32'hFFFF_FFFF))
      `CHK("pre", rows[i].nopre ? 8'h00 : 8'h20, pre)
      bus(1'b1, mfe_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
    end
    bus(1'b1, mfe_pkg::ADDR_DIV, 32'h0000_0000);
    bus(1'b1, mfe_pkg::ADDR_WORD, 32'h5A46_C33C);
    repeat (80) @(posedge clk);
    bus(1'b0, mfe_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK("no launch", 1'b0, rdq[0])
    bus(1'b1, mfe_pkg::ADDR_DIV, 32'h0000_0032);
    wait_irq();
    `CHK("late launch", 32'h5A46_C33C, got)
    bus(1'b1, mfe_pkg::ADDR_IRQ_EN, 32'h0000_0000);
    bus(1'b1, mfe_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
    bus(1'b1, mfe_pkg::ADDR_WORD, 32'h5A46_0F0F);
    rdq = 32'hFFFF_FFFF;
    for (int k = 0; k < 3000 && rdq[0] !== 1'b0; k++)
      bus(1'b0, mfe_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK("idle", 1'b0, rdq[0])
    `CHK("masked", 1'b0, irq)
    bus(1'b0, mfe_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    `CHK("sticky", 1'b1, rdq[0])
    bus(1'b1, mfe_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    bus(1'b0, 8'h20, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rdq)
    `CHK("unmasked", 1'b1, irq)
    bus(1'b1, mfe_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
    bus(1'b0, mfe_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    `CHK("cleared", 1'b0, rdq[0])
    `CHK("irq low", 1'b0, irq)
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    `CHK("clk reset", 1'b0, mclk)
    `CHK("oe reset", 1'b0, moe)
    `CHK("irq reset", 1'b0, irq)
    bus(1'b0, mfe_pkg::ADDR_DIV, 32'h0000_0000);
    `CHK("div reset", 32'h0000_0000, rdq)
    bus(1'b0, mfe_pkg::ADDR_IRQ_EN, 32'h0000_0000);
    `CHK("en reset", 32'h0000_0000, rdq)
    tally_and_finish();
  end
  // Run needs about 17000 cycles; allow well over double
  initial
  begin
    #(8 * 60000);
    n_fail++;
    tally_and_finish();
  end
endmodule
